//--- rtl/pplm_top.sv
`timescale 1ns/1ps
module pplm_top #(
   parameter int POLL_CYCLES = pplm_pkg::POLL_CYC
) (
   // clock and reset
   input  wire logic               pclk,
   input  wire logic               presetn,
   // apb slave
   input  wire logic               psel,
   input  wire logic               penable,
   input  wire logic               pwrite,
   input  wire logic [15:0]        paddr,
   input  wire logic [31:0]        pwdata,
   output logic      [31:0]        prdata,
   output logic                    pready,
   output logic                    pslverr,
   // straps and eeprom load results
   input  wire logic [1:0]         chip_mode_strap,
   input  wire logic [1:0]         tx_shift_strap,
   input  wire logic [2:0]         port_fiber,
   input  wire logic               ee_load_done,
   input  wire logic               ee_load_ok,
   input  wire logic [15:0]        ee_word0,
   input  wire logic [15:0]        ee_word5,
   // internal phys
   input  wire logic               phya_link,
   input  wire logic               phyb_link,
   input  wire logic               phya_rxer,
   input  wire logic               phyb_rxer,
   output pplm_pkg::pplm_tx_s      phya_tx,
   output pplm_pkg::pplm_tx_s      phyb_tx,
   output logic                    phya_reset,
   output logic                    phyb_reset,
   // core side ports
   input  pplm_pkg::pplm_tx_s      core_tx0,
   input  pplm_pkg::pplm_tx_s      core_tx1,
   input  pplm_pkg::pplm_tx_s      core_tx2,
   output logic      [2:0]         port_link,
   // external mii pins
   input  wire logic               mii_rx_clk,
   input  wire logic               mii_receive_error_pin,
   input  wire logic               mii_link_pin,
   output pplm_pkg::pplm_tx_s      mii_tx,
   output logic                    mii_tx_err,
   output logic                    phy_ref_clock_out,
   // management engine request and answer
   output logic                    mi_req_valid,
   output pplm_pkg::pplm_mi_s      mi_req,
   input  wire logic               mi_ack,
   input  wire logic [15:0]        mi_rdata
);
   import pplm_pkg::*;

   logic [2:0]  rclk_sy_r, rerr_sy_r, lnk_sy_r;
   logic        rclk_lv_r, rerr_lv_r, lnk_lv_r;
   logic [7:0]  esc_cfg_r, asic_cfg_r;
   logic        mi_en_r, first_load_r, link_pol_r;
   logic [2:0]  ref_cnt_r;
   pplm_tx_s    pipe_r [TX_PIPE];
   logic [10:0] win_cnt_r;
   logic        win_end;
   logic [2:0]  err_ev, enh_en, drop_r, restart_r, restart_clr;
   logic [2:0]  mi_ok_r, phy_sig;
   logic        phya_err_d_r, phyb_err_d_r, mii_err_ev;
   logic        upstream, downstream, p2_on;
   pplm_st_e    st_r;
   logic [1:0]  port_r;
   logic        busy_r, bad_r;
   logic [15:0] poll_cnt_r;
   logic [31:0] rd_nxt;
   logic [13:0] idx;

   assign upstream   = chip_mode_strap == MODE_UP;
   assign downstream = chip_mode_strap == MODE_DOWN;
   assign p2_on      = chip_mode_strap != MODE_2PORT;
   assign idx        = paddr[15:2];

   // three-stage samplers for the pins that live off our clock
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rclk_sy_r <= 3'h0;
         rerr_sy_r <= 3'h0;
         lnk_sy_r  <= 3'h0;
      end else begin
         rclk_sy_r <= {rclk_sy_r[1:0], mii_rx_clk};
         rerr_sy_r <= {rerr_sy_r[1:0], mii_receive_error_pin};
         lnk_sy_r  <= {lnk_sy_r[1:0], mii_link_pin};
      end
   end

   // a level counts only once stages two and three agree
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rclk_lv_r <= 1'b0;
         rerr_lv_r <= 1'b0;
         lnk_lv_r  <= 1'b0;
      end else begin
         if (rclk_sy_r[1] == rclk_sy_r[2]) rclk_lv_r <= rclk_sy_r[2];
         if (rerr_sy_r[1] == rerr_sy_r[2]) rerr_lv_r <= rerr_sy_r[2];
         if (lnk_sy_r[1] == lnk_sy_r[2])   lnk_lv_r  <= lnk_sy_r[2];
      end
   end

   // receive error is taken at the partner's receive clock rising edge
   assign mii_err_ev = rclk_sy_r[2] && rclk_sy_r[1] && !rclk_lv_r
                       && rerr_lv_r;

   // eeprom capture; the polling enable is latched from the eeprom once per reset only
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         esc_cfg_r    <= 8'h00;
         asic_cfg_r   <= 8'h00;
         mi_en_r      <= 1'b0;
         first_load_r <= 1'b0;
         link_pol_r   <= 1'b0;
      end else begin
         if (ee_load_done && ee_load_ok) begin
            esc_cfg_r  <= ee_word0[15:8];
            asic_cfg_r <= ee_word5[7:0];
         end
         if (ee_load_done && !first_load_r) begin
            first_load_r <= 1'b1;
            mi_en_r      <= ee_load_ok && ee_word5[15];
         end else if (psel && penable && pwrite && idx == IDX_MI_CS) begin
            mi_en_r <= pwdata[MI_CS_LINKDET];
         end
         if (psel && penable && pwrite && idx == IDX_LINK_POL) begin
            link_pol_r <= pwdata[0];
         end
      end
   end

   // apb read mux; unmapped addresses answer with an error
   always_comb begin
      rd_nxt = 32'h0;
      unique case (idx)
         IDX_PORT_DESC: begin
            rd_nxt[1:0] = PCFG_USED;
            rd_nxt[3:2] = PCFG_USED;
            rd_nxt[PD_P2_LSB +: 2] = p2_on ? PCFG_USED : PCFG_NONE;
         end
         IDX_ESC_CFG:   rd_nxt[7:0] = esc_cfg_r;
         IDX_ASIC_CFG:  rd_nxt[7:0] = asic_cfg_r;
         IDX_MI_CS:     rd_nxt[MI_CS_LINKDET] = mi_en_r;
         IDX_LINK_STAT: rd_nxt[11:0] = {drop_r, restart_r, mi_ok_r,
                                        port_link};
         IDX_LINK_POL:  rd_nxt[0] = link_pol_r;
         default:       rd_nxt = 32'h0;
      endcase
   end

   // zero-wait slave: answer in the access cycle itself
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata  <= 32'h0;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready  <= psel && !penable;
         pslverr <= psel && !penable && !(idx inside {IDX_PORT_DESC,
                    IDX_ESC_CFG, IDX_ASIC_CFG, IDX_MI_CS, IDX_LINK_STAT,
                    IDX_LINK_POL});
         if (psel && !penable && !pwrite) prdata <= rd_nxt;
      end
   end

   // 25 MHz reference from the 125 MHz clock, two of five cycles high
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ref_cnt_r         <= 3'h0;
         phy_ref_clock_out <= 1'b0;
      end else begin
         ref_cnt_r <= (ref_cnt_r == 3'(REF_DIV - 1)) ? 3'h0
                      : ref_cnt_r + 3'h1;
         phy_ref_clock_out <= ref_cnt_r < 3'(REF_HIGH);
      end
   end

   // transmit routing; the phy transmit clock is never looked at
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         phya_tx    <= '0;
         phyb_tx    <= '0;
         mii_tx_err <= 1'b0;
         for (int i = 0; i < TX_PIPE; i++) pipe_r[i] <= '0;
      end else begin
         phya_tx <= upstream ? core_tx2 : core_tx0;
         phyb_tx <= core_tx1;
         mii_tx_err <= 1'b0;
         pipe_r[0] <= upstream ? core_tx0 : downstream ? core_tx2 : '0;
         for (int i = 1; i < TX_PIPE; i++) pipe_r[i] <= pipe_r[i-1];
      end
   end

   // shift of n steps costs ceil(n*10ns/8ns) extra cycles
   function automatic int tap_of(input logic [1:0] s);
      return (int'(s) * TX_STEP_NS * CLK_MHZ + 999) / 1000;
   endfunction : tap_of

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) mii_tx <= '0;
      else          mii_tx <= pipe_r[tap_of(tx_shift_strap)];
   end

   // common error-count window, about 10 us
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) win_cnt_r <= 11'h0;
      else          win_cnt_r <= win_end ? 11'h0 : win_cnt_r + 11'h1;
   end
   assign win_end = win_cnt_r == 11'(ENH_WIN_CYC - 1);

   // internal phy error pulses are on our clock, edge-detected here
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         phya_err_d_r <= 1'b0;
         phyb_err_d_r <= 1'b0;
      end else begin
         phya_err_d_r <= phya_rxer;
         phyb_err_d_r <= phyb_rxer;
      end
   end

   assign err_ev[0] = upstream ? mii_err_ev : (phya_rxer && !phya_err_d_r);
   assign err_ev[1] = phyb_rxer && !phyb_err_d_r;
   assign err_ev[2] = upstream ? (phya_rxer && !phya_err_d_r)
                      : downstream ? mii_err_ev : 1'b0;
   assign phy_sig[0] = upstream ? (lnk_lv_r ^ link_pol_r) : phya_link;
   assign phy_sig[1] = phyb_link;
   assign phy_sig[2] = upstream ? phya_link
                       : downstream && (lnk_lv_r ^ link_pol_r);

   // per-port enhanced link detection and link combination
   for (genvar p = 0; p < 3; p++) begin : g_port
      logic [5:0] cnt_r;
      logic       hit;
      assign enh_en[p] = esc_cfg_r[ESC_ENH_ALL] || esc_cfg_r[ESC_ENH_P0+p];
      assign hit = enh_en[p] && err_ev[p]
                   && cnt_r == 6'(ENH_ERR_LIMIT - 1);
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            cnt_r        <= 6'h0;
            drop_r[p]    <= 1'b0;
            restart_r[p] <= 1'b0;
            port_link[p] <= 1'b0;
         end else begin
            if (win_end)                        cnt_r <= 6'h0;
            else if (err_ev[p] && !cnt_r[5])    cnt_r <= cnt_r + 6'h1;
            // drop at the 32nd error, release after a window with fewer than 32 errors
            if (hit)                            drop_r[p] <= 1'b1;
            else if (win_end && !cnt_r[5])      drop_r[p] <= 1'b0;
            // a new hit at the 32nd error beats the clear from the poller
            if (hit)                            restart_r[p] <= 1'b1;
            else if (restart_clr[p])            restart_r[p] <= 1'b0;
            port_link[p] <= phy_sig[p] && (mi_ok_r[p] || !mi_en_r)
                            && !drop_r[p] && (p != 2 || p2_on);
         end
      end
   end

   // poller: each enabled port in turn, restarts served first
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_r         <= ST_WAIT;
         port_r       <= 2'h0;
         busy_r       <= 1'b0;
         bad_r        <= 1'b0;
         poll_cnt_r   <= 16'h0;
         mi_ok_r      <= 3'h0;
         mi_req_valid <= 1'b0;
         mi_req       <= '0;
         restart_clr  <= 3'h0;
         phya_reset   <= 1'b0;
         phyb_reset   <= 1'b0;
      end else begin
         restart_clr <= 3'h0;
         phya_reset  <= 1'b0;
         phyb_reset  <= 1'b0;
         unique case (st_r)
            ST_WAIT: begin
               poll_cnt_r <= poll_cnt_r + 16'h1;
               if (poll_cnt_r == 16'(POLL_CYCLES - 1)) begin
                  poll_cnt_r <= 16'h0;
                  port_r     <= 2'h0;
                  st_r       <= ST_RD_CTRL;
               end
            end
            ST_NEXT: begin
               if (port_r == 2'h2 || (port_r == 2'h1 && !p2_on)) begin
                  st_r <= ST_WAIT;
               end else begin
                  port_r <= port_r + 2'h1;
                  st_r   <= ST_RD_CTRL;
               end
            end
            default: begin
               if (!busy_r) begin
                  // skip ports with nothing to do; fiber has no autoneg
                  if (st_r == ST_RD_CTRL && restart_r[port_r]) begin
                     st_r <= ST_WR_ADV;
                  end else if (st_r == ST_RD_CTRL
                               && (!mi_en_r || port_fiber[port_r])) begin
                     st_r <= ST_NEXT;
                  end else if (st_r == ST_WR_GIG
                               && !asic_cfg_r[ASIC_REG9_WE]) begin
                     st_r <= ST_WR_CTRL;
                  end else begin
                     busy_r          <= 1'b1;
                     mi_req_valid    <= 1'b1;
                     mi_req.phy      <= {3'h0, port_r};
                     mi_req.wr       <= st_r inside {ST_WR_ADV, ST_WR_GIG,
                                                     ST_WR_CTRL};
                     mi_req.regad    <= st_r == ST_RD_CTRL ? PREG_CTRL
                                      : st_r == ST_RD_ADV  ? PREG_ADV
                                      : st_r == ST_RD_GIG  ? PREG_GIG
                                      : st_r == ST_RD_STAT ? PREG_STAT
                                      : st_r == ST_RD_LPA  ? PREG_LPA
                                      : st_r == ST_WR_ADV  ? PREG_ADV
                                      : st_r == ST_WR_GIG  ? PREG_GIG
                                      : PREG_CTRL;
                     mi_req.wdata    <= st_r == ST_WR_ADV ? ADV_WRITE
                                      : st_r == ST_WR_GIG ? GIG_WRITE
                                      : CTRL_WRITE;
                     if (st_r == ST_RD_CTRL) bad_r <= 1'b0;
                  end
               end else if (mi_ack) begin
                  busy_r       <= 1'b0;
                  mi_req_valid <= 1'b0;
                  unique case (st_r)
                     ST_RD_CTRL: begin
                        if (!mi_rdata[CTRL_AN_EN]) bad_r <= 1'b1;
                        st_r <= ST_RD_ADV;
                     end
                     ST_RD_ADV: begin
                        if ((mi_rdata & ADV_MASK) != 16'(1 << ABIL_100FD))
                           bad_r <= 1'b1;
                        st_r <= ST_RD_GIG;
                     end
                     ST_RD_GIG: begin
                        if ((mi_rdata & GIG_MASK) != 16'h0)
                           bad_r <= 1'b1;
                        // this read's own verdict is not in bad_r yet
                        st_r <= (bad_r || (mi_rdata & GIG_MASK) != 16'h0)
                                ? ST_WR_ADV : ST_RD_STAT;
                     end
                     ST_RD_STAT: begin
                        mi_ok_r[port_r] <= 1'b0;
                        // no link or autoneg still running: look again later
                        st_r <= (mi_rdata[STAT_LINK] && mi_rdata[STAT_AN_DONE])
                                ? ST_RD_LPA : ST_NEXT;
                     end
                     ST_RD_LPA: begin
                        mi_ok_r[port_r] <= mi_rdata[ABIL_100FD];
                        st_r <= mi_rdata[ABIL_100FD] ? ST_NEXT
                                : ST_WR_ADV;
                     end
                     ST_WR_ADV: st_r <= ST_WR_GIG;
                     ST_WR_GIG: st_r <= ST_WR_CTRL;
                     ST_WR_CTRL: begin
                        mi_ok_r[port_r]     <= 1'b0;
                        restart_clr[port_r] <= 1'b1;
                        if (port_fiber[port_r]) begin
                           phyb_reset <= port_r == 2'h1;
                           phya_reset <= (port_r == 2'h0 && !upstream)
                                         || (port_r == 2'h2 && upstream);
                        end
                        st_r <= ST_NEXT;
                     end
                     default: st_r <= ST_NEXT;
                  endcase
               end
            end
         endcase
      end
   end
endmodule : pplm_top

//--- inc/pplm_pkg.sv
package pplm_pkg;
   // timing
   localparam int          CLK_MHZ       = 125;
   localparam int          REF_MHZ       = 25;
   localparam int          REF_DIV       = CLK_MHZ / REF_MHZ;
   localparam int          REF_HIGH      = REF_DIV / 2;
   localparam int          ENH_WIN_NS    = 10000;
   localparam int          ENH_WIN_CYC   = ENH_WIN_NS * CLK_MHZ / 1000;
   localparam int          ENH_ERR_LIMIT = 32;
   localparam int          TX_STEP_NS    = 10;
   localparam int          POLL_US       = 100;
   localparam int          POLL_CYC      = POLL_US * CLK_MHZ;
   localparam int          TX_PIPE       = 5;
   // topology strap codes and port descriptor codes
   localparam logic [1:0]  MODE_2PORT    = 2'h0;
   localparam logic [1:0]  MODE_DOWN     = 2'h2;
   localparam logic [1:0]  MODE_UP       = 2'h3;
   localparam logic [1:0]  PCFG_NONE     = 2'h1;
   localparam logic [1:0]  PCFG_USED     = 2'h3;
   // register indices, byte address is four times the index
   localparam logic [13:0] IDX_PORT_DESC = 14'h007;
   localparam logic [13:0] IDX_ESC_CFG   = 14'h141;
   localparam logic [13:0] IDX_ASIC_CFG  = 14'h142;
   localparam logic [13:0] IDX_MI_CS     = 14'h510;
   localparam logic [13:0] IDX_LINK_STAT = 14'h520;
   localparam logic [13:0] IDX_LINK_POL  = 14'h521;
   // field positions
   localparam int          ESC_ENH_ALL   = 1;
   localparam int          ESC_ENH_P0    = 4;
   localparam int          ASIC_REG9_WE  = 7;
   localparam int          MI_CS_LINKDET = 2;
   localparam int          PD_P2_LSB     = 4;
   // phy register numbers and fields
   localparam logic [4:0]  PREG_CTRL     = 5'h00;
   localparam logic [4:0]  PREG_STAT     = 5'h01;
   localparam logic [4:0]  PREG_ADV      = 5'h04;
   localparam logic [4:0]  PREG_LPA      = 5'h05;
   localparam logic [4:0]  PREG_GIG      = 5'h09;
   localparam int          CTRL_AN_EN    = 12;
   localparam int          STAT_LINK     = 2;
   localparam int          STAT_AN_DONE  = 5;
   localparam int          ABIL_100FD    = 8;
   localparam logic [15:0] ADV_MASK      = 16'h01e0;
   localparam logic [15:0] GIG_MASK      = 16'h0300;
   localparam logic [15:0] ADV_WRITE     = 16'h0101;
   localparam logic [15:0] GIG_WRITE     = 16'h0000;
   localparam logic [15:0] CTRL_WRITE    = 16'h3300;

   typedef struct packed {
      logic       en;
      logic [3:0] d;
   } pplm_tx_s;

   typedef struct packed {
      logic        wr;
      logic [4:0]  phy;
      logic [4:0]  regad;
      logic [15:0] wdata;
   } pplm_mi_s;

   typedef enum logic [3:0] {
      ST_WAIT    = 4'h0,
      ST_RD_CTRL = 4'h1,
      ST_RD_ADV  = 4'h2,
      ST_RD_GIG  = 4'h3,
      ST_RD_STAT = 4'h4,
      ST_RD_LPA  = 4'h5,
      ST_WR_ADV  = 4'h6,
      ST_WR_GIG  = 4'h7,
      ST_WR_CTRL = 4'h8,
      ST_NEXT    = 4'h9
   } pplm_st_e;
endpackage : pplm_pkg

//--- test/pplm_chk_sva.sv
`timescale 1ns/1ps
// port-level checks; everything waits while reset is low
module pplm_chk
   import pplm_pkg::*;
#(parameter int POLL_CYCLES = 50) (
   // clock, reset and straps
   input wire logic          pclk,
   input wire logic          presetn,
   input wire logic [1:0]    chip_mode_strap,
   input wire logic [1:0]    tx_shift_strap,
   // transmit paths
   input pplm_pkg::pplm_tx_s core_tx0,
   input pplm_pkg::pplm_tx_s core_tx1,
   input pplm_pkg::pplm_tx_s core_tx2,
   input pplm_pkg::pplm_tx_s phya_tx,
   input pplm_pkg::pplm_tx_s phyb_tx,
   input pplm_pkg::pplm_tx_s mii_tx,
   input wire logic          mii_tx_err,
   input wire logic          phy_ref_clock_out,
   // management and link
   input wire logic          mi_req_valid,
   input pplm_pkg::pplm_mi_s mi_req,
   input wire logic          mi_ack,
   input wire logic [2:0]    port_link
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   wire up    = chip_mode_strap == MODE_UP;
   wire ref_c = phy_ref_clock_out;
   property p_no_err; !mii_tx_err; endproperty
   a_no_err: assert property (p_no_err) else $error("tx err");
   // two high, three low at the 125 MHz clock
   property p_ref;
      $rose(ref_c) |=> ref_c ##1 !ref_c [*3] ##1 ref_c;
   endproperty
   a_ref: assert property (p_ref) else $error("ref shape");
   property p_paths;
      phya_tx == (up ? $past(core_tx2) : $past(core_tx0)) &&
         phyb_tx == $past(core_tx1);
   endproperty
   a_paths: assert property (p_paths)
      else $error("phy path");
   // one stage in front of the tap pipe and one behind it
   property p_mii_up;
      up && !tx_shift_strap |-> mii_tx == $past(core_tx0, 2);
   endproperty
   a_mii_up: assert property (p_mii_up) else $error("mii up");
   property p_mii_dn;
      chip_mode_strap == MODE_DOWN && !tx_shift_strap |->
         mii_tx == $past(core_tx2, 2);
   endproperty
   a_mii_dn: assert property (p_mii_dn)
      else $error("mii down");
   property p_hold;
      mi_req_valid && !mi_ack |=> mi_req_valid && $stable(mi_req);
   endproperty
   a_hold: assert property (p_hold) else $error("mi hold");
   // only the three repair writes, each with its fixed value
   property p_wdata;
      mi_req_valid && mi_req.wr |->
         mi_req.regad == PREG_ADV && mi_req.wdata == ADV_WRITE ||
         mi_req.regad == PREG_GIG && mi_req.wdata == GIG_WRITE ||
         mi_req.regad == PREG_CTRL && mi_req.wdata == CTRL_WRITE;
   endproperty
   a_wdata: assert property (p_wdata) else $error("mi write");
   property p_p2off;
      chip_mode_strap == MODE_2PORT |->
         !port_link[2] && !(mi_req_valid && mi_req.phy == 5'h2);
   endproperty
   a_p2off: assert property (p_p2off)
      else $error("port2 on");
   c_wr: cover property (mi_req_valid && mi_req.wr);
   c_drop: cover property ($fell(port_link[1]));
   c_ack: cover property (mi_ack);
endmodule : pplm_chk

//--- test/pplm_phy_model.sv
`timescale 1ns/1ps
// far side: management answers, receive clock, link and error pins
module pplm_phy_model
   import pplm_pkg::*;
(
   // clock, reset and test control
   input wire logic          pclk,
   input wire logic          presetn,
   input wire logic          cfg_bad,
   // management and mii pins
   input wire logic          mi_req_valid,
   input pplm_pkg::pplm_mi_s mi_req,
   output logic              mi_ack,
   output logic [15:0]       mi_rdata,
   output logic              rx_clk,
   output logic              rx_er,
   output logic              link
);
   logic [1:0] lat_r;
   logic [1:0] cnt_r;
   // latency walks 1..4 cycles; idle data toggles so stale reads show
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         {lat_r, cnt_r, mi_ack, mi_rdata} <= '0;
      end else begin
         mi_ack <= 1'b0;
         mi_rdata <= ~mi_rdata;
         cnt_r <= (mi_req_valid && !mi_ack) ? cnt_r + 2'h1 : 2'h0;
         if (mi_req_valid && !mi_ack && cnt_r == lat_r) begin
            mi_ack <= 1'b1;
            lat_r <= lat_r + 2'h1;
            // a restart command resets the phy to its start latency
            if (mi_req.wr && mi_req.wdata[9] && mi_req.regad == PREG_CTRL)
               lat_r <= 2'h0;
            // cfg_bad spoils the advert so the block must repair it
            case (mi_req.regad)
               PREG_CTRL: mi_rdata <= 16'h1000;
               PREG_ADV:  mi_rdata <= cfg_bad ? 16'h01e1 : 16'h0101;
               PREG_STAT: mi_rdata <= 16'h0024;
               PREG_LPA:  mi_rdata <= 16'h0100;
               default:   mi_rdata <= 16'h0000;
            endcase
         end
      end
   end
   // free running receive clock in its own phase
   initial begin
      rx_clk = 1'b0;
      #13;
      forever #40 rx_clk = ~rx_clk;
   end
   assign rx_er = 1'b0;
   assign link  = 1'b1;
endmodule : pplm_phy_model

//--- test/tb_top.sv
`timescale 1ns/1ps
module tb_top;
   import pplm_pkg::*;
   logic            pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic            ee_done, ee_ok, rb, rxc, rxe, lpin, bad, tx_on;
   logic            pa_rst, pb_rst, tx_err, refo, mi_v, mi_ack;
   logic [1:0]      mode, shift;
   logic [2:0]      fib, plink;
   logic [15:0]     paddr, mi_rd;
   logic [31:0]     pwdata, prdata;
   logic [33:0]     expq[$], e_n;
   logic [5:0][4:0] hist;
   pplm_tx_s        t0, t1, t2, pa_tx, pb_tx, mtx;
   pplm_mi_s        mi_req;
   int              err_count, cmp_count, wr_n, pb_n, tap;
   integer          seed = 80220;
   pplm_top #(.POLL_CYCLES(50)) pplm_top_i (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .chip_mode_strap(mode),
      .tx_shift_strap(shift), .port_fiber(fib), .ee_load_done(ee_done),
      .ee_load_ok(ee_ok), .ee_word0(16'h0200), .ee_word5(16'h8080),
      .phya_link(tx_on), .phyb_link(tx_on), .phya_rxer(1'b0), .phyb_rxer(rb),
      .phya_tx(pa_tx), .phyb_tx(pb_tx), .phya_reset(pa_rst),
      .phyb_reset(pb_rst), .core_tx0(t0), .core_tx1(t1), .core_tx2(t2),
      .port_link(plink), .mii_rx_clk(rxc), .mii_receive_error_pin(rxe),
      .mii_link_pin(lpin), .mii_tx(mtx), .mii_tx_err(tx_err),
      .phy_ref_clock_out(refo), .mi_req_valid(mi_v), .mi_req(mi_req),
      .mi_ack(mi_ack), .mi_rdata(mi_rd));
   pplm_phy_model pplm_phy_model_i (.pclk(pclk), .presetn(presetn),
      .cfg_bad(bad), .mi_req_valid(mi_v), .mi_req(mi_req), .mi_ack(mi_ack),
      .mi_rdata(mi_rd), .rx_clk(rxc), .rx_er(rxe), .link(lpin));
   initial begin
      pclk = 1'b0;
      forever #4 pclk = ~pclk;
   end
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         err_count++;
         $display("mismatch at %0t got %h exp %h", $time, got, exp);
      end
   endtask : cmp
   // e: bit 33 compare data, bit 32 expected error flag
   task automatic apb(input logic w, input logic [13:0] ix,
                      input logic [31:0] d, input logic [33:0] e);
      {psel, pwrite, paddr, pwdata} <= {1'b1, w, ix, 2'h0, d};
      expq.push_back(e);
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      {psel, penable} <= 2'h0;
      @(posedge pclk);
   endtask : apb
   // apb answers against the oldest note; tx nibbles against their history
   always @(posedge pclk) begin
      if (pready && expq.size() > 0) begin
         e_n = expq.pop_front();
         cmp({31'h0, pslverr}, {31'h0, e_n[32]});
         if (e_n[33]) cmp(prdata, e_n[31:0]);
      end
      if (tx_on && mode[1])
         cmp({27'h0, mtx}, {27'h0, hist[tap + 1]});
      hist <= {hist[4:0], mode == MODE_UP ? t0 : t2};
      {t0, t1, t2} <= tx_on ? 15'($random(seed)) : 15'h0;
      wr_n <= wr_n + int'(mi_v && mi_ack && mi_req.wr);
      pb_n <= pb_n + int'(pb_rst);
   end
   // one topology, from reset to an enhanced link loss
   task automatic run(input logic [1:0] m, input logic [1:0] s,
                      input logic [2:0] f, input logic b);
      int w0;
      int p0;
      {presetn, tx_on, mode, shift, fib, bad} <= {2'h0, m, s, f, b};
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      tap = (int'(s) * TX_STEP_NS + 7) / 8;
      repeat (8) @(posedge pclk);
      tx_on <= 1'b1;
      // failed first load, then a good reload that must not arm polling
      for (int i = 0; i < 2; i++) begin
         {ee_done, ee_ok} <= {1'b1, i[0]};
         @(posedge pclk);
         ee_done <= 1'b0;
         @(posedge pclk);
      end
      apb(0, IDX_MI_CS, 0, {2'h2, 32'h0});
      apb(0, IDX_PORT_DESC, 0, {2'h2, m ? 32'h3f : 32'h1f});
      apb(1, 14'h100, 5, {2'h1, 32'h0});
      apb(0, IDX_LINK_STAT, 0,
          {2'h2, m ? 32'h7 : 32'h3});
      apb(1, IDX_LINK_POL, 1, 34'h0);
      repeat (8) @(posedge pclk);
      apb(0, IDX_LINK_STAT, 0,
          {2'h2, m == MODE_UP ? 32'h6 : 32'h3});
      apb(1, IDX_LINK_POL, 0, 34'h0);
      if (f == 3'h0) apb(1, IDX_MI_CS, 4, 34'h0);
      w0 = wr_n;
      repeat (400) @(posedge pclk);
      cmp(32'(wr_n > w0), 32'(b));
      p0 = pb_n;
      // 70 errors: any window split still leaves 32 in one window
      repeat (70) begin
         rb <= 1'b1;
         @(posedge pclk);
         rb <= 1'b0;
         @(posedge pclk);
      end
      cmp({31'h0, plink[1]}, 32'h0);
      // the pending restart is served only at the poller's next scan
      repeat (150) @(posedge pclk);
      cmp(32'(pb_n > p0), 32'(f[1]));
      $display("test done: mode %0d shift %0d", m, s);
   endtask : run
   task automatic wrap_up();
      $display("compared %0d, mismatched %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : wrap_up
   // the runs take about 4000 cycles
   initial begin
      repeat (20000) @(posedge pclk);
      err_count++;
      wrap_up();
   end
   initial begin
      {presetn, psel, penable, pwrite, paddr, pwdata, ee_done, ee_ok} = '0;
      {mode, shift, fib, bad, tx_on, rb, t0, t1, t2, hist} = '0;
      {err_count, cmp_count, wr_n, pb_n, tap} = '0;
      run(MODE_2PORT, 2'h1, 3'h0, 1'b0);
      run(MODE_DOWN, 2'h0, 3'h0, 1'b1);
      run(MODE_UP, 2'h0, 3'h0, 1'b0);
      run(MODE_UP, 2'h2, 3'h2, 1'b0);
      run(MODE_DOWN, 2'h3, 3'h0, 1'b0);
      wrap_up();
   end
endmodule : tb_top
bind pplm_top pplm_chk #(.POLL_CYCLES(POLL_CYCLES)) pplm_chk_i (
   .pclk(pclk), .presetn(presetn), .chip_mode_strap(chip_mode_strap),
   .tx_shift_strap(tx_shift_strap), .core_tx0(core_tx0),
   .core_tx1(core_tx1), .core_tx2(core_tx2), .phya_tx(phya_tx),
   .phyb_tx(phyb_tx), .mii_tx(mii_tx), .mii_tx_err(mii_tx_err),
   .phy_ref_clock_out(phy_ref_clock_out), .mi_req_valid(mi_req_valid),
   .mi_req(mi_req), .mi_ack(mi_ack), .port_link(port_link));
